/* phy_carrier_collision_status.sv */
/*
  Carrier sense, collision and speed indication of a 10/100 PHY toward its
  MAC, with an AHB-Lite register slave and a receive-side link clock domain.
  Assumes one AHB-Lite master doing single word transfers, TX_EN and the
  management pins asynchronous, and the link front end on LINK_CLK.
*/
// The implementer's own choices: the address map and the AHB-Lite interface to the registers.
// Notes on behaviour
// - Speed output low for 10 Mb/s, high for 100 Mb/s.
// - Reset input low holds block in reset; high means operational.
// - Collision asserts on receive activity while transmit enable is high.
// - 100 Mb/s receive active when a 10-bit window has two non-adjacent zeros.
// - 10 Mb/s receive activity is the line signal after squelch release.
// - Collision output need not follow receive or transmit clock timing.
// - Full duplex forces collision output permanently low.
// - Heartbeat test asserts collision unless the suppress bit is set; the code raises it only after a 10 Mb/s half duplex transmission.
// - Half duplex carrier sense follows receive or transmit activity.
// - Full duplex or repeater carrier sense follows receive activity only.
// - Carrier sense output need not follow receive or transmit clock timing.
// - Management data is sampled only on management clock edges.
`default_nettype none
`include "phy_carrier_collision_status_regs.svh"

module phy_carrier_collision_status
  import phy_ccs_pkg::*;
(
  // System clock and reset
  input  wire logic        CLK,
  input  wire logic        RST_N,
  // AHB-Lite slave
  input  wire logic        HSEL,
  input  wire logic [31:0] HADDR,
  input  wire logic [1:0]  HTRANS,
  input  wire logic        HWRITE,
  input  wire logic [2:0]  HSIZE,
  input  wire logic [31:0] HWDATA,
  input  wire logic        HREADY,
  output var  logic [31:0] HRDATA,
  output var  logic        HREADYOUT,
  output var  logic        HRESP,
  // MAC side
  input  wire logic        TX_EN,
  output var  logic        CRS,
  output var  logic        COL,
  output var  logic        SPEED_OUT,
  // Link front end
  input  wire logic        LINK_CLK,
  input  wire logic        RX_BIT,
  input  wire logic        SQUELCH_OPEN,
  input  wire logic        LINE_ACTIVE,
  // Management pins
  input  wire logic        MDC,
  input  wire logic        MDIO_I
);

  // Register state
  ctrl_t             ctrl_ff;
  ctrl_t             nxt_ctrl;
  logic [15:0]       col_cnt_ff;
  logic [15:0]       nxt_col_cnt;
  logic [15:0]       crs_cnt_ff;
  logic [15:0]       nxt_crs_cnt;
  logic [15:0]       mgmt_shift_ff;
  logic [15:0]       nxt_mgmt_shift;

  // Bus pipeline
  logic              wr_pend_ff;
  logic [31:0]       wr_addr_ff;
  logic              hreadyout_ff;
  logic              hresp_ff;
  logic [31:0]       hrdata_ff;
  logic [31:0]       nxt_hrdata;

  // Line state
  logic              crs_ff;
  logic              col_ff;
  logic              speed_ff;
  logic              crs_d_ff;
  logic              col_d_ff;
  logic              mdc_d_ff;
  hb_state_t         hb_state_ff;
  hb_state_t         nxt_hb_state;
  logic [7:0]        hb_cnt_ff;
  logic [7:0]        nxt_hb_cnt;
  logic              tx_d_ff;

  // Crossing wires
  async_in_t         async_raw;
  async_in_t         async_s;
  logic              link_act100;
  logic              link_act10;

  // Decode wires
  logic              addr_ok;
  logic              rd_take;
  logic              wr_take;
  logic              wr_now;
  logic              wr_ctrl;
  logic              wr_count;
  logic              fwd_ctrl;
  ctrl_t             ctrl_view;
  status_t           status_view;
  logic              rx_active;
  logic              tx_active;
  logic              half_duplex;
  logic              crs_own_tx;
  logic              nxt_crs;
  logic              nxt_col;
  logic              hb_arm;
  logic              hb_wait_done;
  logic              hb_pulse_done;
  logic              crs_rise;
  logic              col_rise;
  logic              mdc_rise;

  // Address match for one register offset
  function automatic logic addr_is(input logic [31:0] a, input logic [31:0] ofs);
    return a == ofs;
  endfunction

  // Rising edge of a registered level
  function automatic logic rise_of(input logic cur, input logic prev);
    return cur && !prev;
  endfunction

  // Heartbeat counter reached its last cycle
  function automatic logic hb_at(input logic [7:0] cnt, input logic [7:0] last);
    return cnt == last;
  endfunction

  // Count update; an edge in the clear cycle leaves a count of one
  function automatic logic [15:0] cnt_next(input logic        rise,
                                           input logic        clr,
                                           input logic [15:0] cnt);
    logic [15:0] val;
    val = cnt;
    if (clr) begin
      val = `COUNT_RESET;
    end
    if (rise) begin
      val = val + `CNT_ONE;
    end
    return val;
  endfunction

  // Receive activity detection lives on the link clock
  ccs_rx_activity u_rx_activity (
    .clk_link     (LINK_CLK),
    .rst_n        (RST_N),
    .rx_bit       (RX_BIT),
    .squelch_open (SQUELCH_OPEN),
    .line_active  (LINE_ACTIVE),
    .act100_ff    (link_act100),
    .act10_ff     (link_act10)
  );

  // Every foreign level crosses through two flops before use
  assign async_raw.mdc    = MDC;
  assign async_raw.mdio   = MDIO_I;
  assign async_raw.tx_en  = TX_EN;
  assign async_raw.act100 = link_act100;
  assign async_raw.act10  = link_act10;

  ccs_sync2 u_sync2 (
    .clk   (CLK),
    .rst_n (RST_N),
    .d     (async_raw),
    .q     (async_s)
  );

  // Bus decode
  assign addr_ok  = addr_is(HADDR, `CTRL_OFS) || addr_is(HADDR, `STATUS_OFS) ||
                    addr_is(HADDR, `COUNT_OFS) || addr_is(HADDR, `MGMT_OFS);
  assign rd_take  = HSEL && HREADY && HTRANS[1] && !HWRITE;
  assign wr_take  = HSEL && HREADY && HTRANS[1] && HWRITE && (HSIZE == `HSIZE_WORD);
  assign wr_now   = wr_pend_ff && HREADY;
  assign wr_ctrl  = wr_now && addr_is(wr_addr_ff, `CTRL_OFS);
  assign wr_count = wr_now && addr_is(wr_addr_ff, `COUNT_OFS);

  // A read right behind a control write sees the new value
  assign fwd_ctrl  = wr_ctrl && addr_is(HADDR, `CTRL_OFS);
  assign ctrl_view = fwd_ctrl ? ctrl_t'(HWDATA[`CTRL_W-1:0]) : ctrl_ff;

  assign nxt_ctrl = wr_ctrl ? ctrl_t'(HWDATA[`CTRL_W-1:0]) : ctrl_ff;

  // Activity selection
  assign rx_active   = ctrl_ff.speed100 ? async_s.act100 : async_s.act10;
  assign tx_active   = async_s.tx_en;
  assign half_duplex = !ctrl_ff.full_duplex;
  assign crs_own_tx  = half_duplex && !ctrl_ff.repeater;

  // Own transmissions count only in plain half duplex
  assign nxt_crs = rx_active || (crs_own_tx && tx_active);

  // Heartbeat follows the end of a 10 Mb/s half duplex transmission
  assign hb_arm        = tx_d_ff && !tx_active && !ctrl_ff.speed100 && half_duplex &&
                         !ctrl_ff.heartbeat_test_suppress;
  assign hb_wait_done  = hb_at(hb_cnt_ff, 8'(`HB_DELAY_CYC - 1));
  assign hb_pulse_done = hb_at(hb_cnt_ff, 8'(`HB_LEN_CYC - 1));

  always_comb begin
    nxt_hb_state = hb_state_ff;
    nxt_hb_cnt   = hb_cnt_ff + 8'h01;
    case (hb_state_ff)
      HB_IDLE: begin
        nxt_hb_cnt = `HB_CNT_ZERO;
        if (hb_arm) begin
          nxt_hb_state = HB_WAIT;
        end
      end
      HB_WAIT: begin
        if (tx_active || ctrl_ff.heartbeat_test_suppress) begin
          nxt_hb_state = HB_IDLE;
          nxt_hb_cnt   = `HB_CNT_ZERO;
        end else if (hb_wait_done) begin
          nxt_hb_state = HB_PULSE;
          nxt_hb_cnt   = `HB_CNT_ZERO;
        end
      end
      HB_PULSE: begin
        if (hb_pulse_done || ctrl_ff.heartbeat_test_suppress) begin
          nxt_hb_state = HB_IDLE;
          nxt_hb_cnt   = `HB_CNT_ZERO;
        end
      end
      default: begin
        nxt_hb_state = HB_IDLE;
        nxt_hb_cnt   = `HB_CNT_ZERO;
      end
    endcase
  end

  // Collision: overlap of activity or heartbeat, never in full duplex
  assign nxt_col = !ctrl_ff.full_duplex &&
                   ((rx_active && tx_active) ||
                    (hb_state_ff == HB_PULSE));

  // Event counters; a count event in the same cycle as a clear leaves a count of one
  assign crs_rise    = rise_of(crs_ff, crs_d_ff);
  assign col_rise    = rise_of(col_ff, col_d_ff);
  assign nxt_crs_cnt = cnt_next(crs_rise, wr_count, crs_cnt_ff);
  assign nxt_col_cnt = cnt_next(col_rise, wr_count, col_cnt_ff);

  // Management data is only looked at on a clean management clock rise
  assign mdc_rise       = rise_of(async_s.mdc, mdc_d_ff);
  assign nxt_mgmt_shift = mdc_rise ? {mgmt_shift_ff[14:0], async_s.mdio} :
                          mgmt_shift_ff;

  // Status view
  assign status_view.hb_pulse  = hb_state_ff == HB_PULSE;
  assign status_view.col       = col_ff;
  assign status_view.crs       = crs_ff;
  assign status_view.tx_active = tx_active;
  assign status_view.rx_active = rx_active;
  assign status_view.speed100  = speed_ff;

  // Read mux; unmapped offsets read as zero
  always_comb begin
    nxt_hrdata = `DATA_ZERO;
    if (rd_take && addr_ok) begin
      if (addr_is(HADDR, `CTRL_OFS)) begin
        nxt_hrdata[`CTRL_W-1:0] = ctrl_view;
      end else if (addr_is(HADDR, `STATUS_OFS)) begin
        nxt_hrdata[`STATUS_W-1:0] = status_view;
      end else if (addr_is(HADDR, `COUNT_OFS)) begin
        nxt_hrdata = {col_cnt_ff, crs_cnt_ff};
      end else begin
        nxt_hrdata[`COUNT_LO-1:0] = mgmt_shift_ff;
      end
    end
  end

  // Bus slave: zero wait states, always OKAY
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      wr_pend_ff   <= 1'b0;
      wr_addr_ff   <= `DATA_ZERO;
      hrdata_ff    <= `DATA_ZERO;
      hreadyout_ff <= 1'b1;
      hresp_ff     <= `HRESP_OKAY;
    end else begin
      if (HREADY) begin
        wr_pend_ff <= wr_take;
        wr_addr_ff <= HADDR;
        hrdata_ff  <= nxt_hrdata;
      end
      hreadyout_ff <= 1'b1;
      hresp_ff     <= `HRESP_OKAY;
    end
  end

  // Holding reset low keeps every register at its reset value
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      ctrl_ff       <= ctrl_t'(`CTRL_RESET);
      col_cnt_ff    <= `COUNT_RESET;
      crs_cnt_ff    <= `COUNT_RESET;
      mgmt_shift_ff <= `MGMT_RESET;
    end else begin
      ctrl_ff       <= nxt_ctrl;
      col_cnt_ff    <= nxt_col_cnt;
      crs_cnt_ff    <= nxt_crs_cnt;
      mgmt_shift_ff <= nxt_mgmt_shift;
    end
  end

  // Line outputs run on the system clock, unrelated to MII clocks
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      crs_ff      <= 1'b0;
      col_ff      <= 1'b0;
      speed_ff    <= 1'b0;
      crs_d_ff    <= 1'b0;
      col_d_ff    <= 1'b0;
      mdc_d_ff    <= 1'b0;
      tx_d_ff     <= 1'b0;
      hb_state_ff <= HB_IDLE;
      hb_cnt_ff   <= `HB_CNT_ZERO;
    end else begin
      crs_ff      <= nxt_crs;
      col_ff      <= nxt_col;
      speed_ff    <= nxt_ctrl.speed100;
      crs_d_ff    <= crs_ff;
      col_d_ff    <= col_ff;
      mdc_d_ff    <= async_s.mdc;
      tx_d_ff     <= tx_active;
      hb_state_ff <= nxt_hb_state;
      hb_cnt_ff   <= nxt_hb_cnt;
    end
  end

  // Outputs straight from flops
  assign HRDATA    = hrdata_ff;
  assign HREADYOUT = hreadyout_ff;
  assign HRESP     = hresp_ff;
  assign CRS       = crs_ff;
  assign COL       = col_ff;
  assign SPEED_OUT = speed_ff;

endmodule

`default_nettype wire

/* phy_carrier_collision_status_regs.svh */
/*
  Register offsets, reset values, field positions and timing counts
  of the carrier and collision status block.
  Assumes inclusion by bare name from every file that needs them.
*/
`ifndef PHY_CARRIER_COLLISION_STATUS_REGS_SVH
`define PHY_CARRIER_COLLISION_STATUS_REGS_SVH

`define CTRL_OFS        32'h0000_0000
`define STATUS_OFS      32'h0000_0004
`define COUNT_OFS       32'h0000_0008
`define MGMT_OFS        32'h0000_000c

`define CTRL_RESET      4'h0
`define COUNT_RESET     16'h0000
`define MGMT_RESET      16'h0000
`define DATA_ZERO       32'h0000_0000
`define CTRL_W          4
`define STATUS_W        6
`define COUNT_LO        16
`define HSIZE_WORD      3'h2
`define HRESP_OKAY      1'h0

`define SYM_IDLE        10'h3ff
`define SYM_BITS        10

`define CLK_PERIOD_NS   8
`define HB_DELAY_NS     800
`define HB_LEN_NS       1000
`define HB_DELAY_CYC    ((`HB_DELAY_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define HB_LEN_CYC      ((`HB_LEN_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define HB_CNT_ZERO     8'h00
`define CNT_ONE         16'h0001

`endif

/* phy_ccs_pkg.sv */
/*
  Types shared by the carrier and collision status block.
  Assumes nothing of its surroundings.
*/
`default_nettype none

package phy_ccs_pkg;

  typedef struct packed {
    logic heartbeat_test_suppress;
    logic repeater;
    logic full_duplex;
    logic speed100;
  } ctrl_t;

  typedef struct packed {
    logic hb_pulse;
    logic col;
    logic crs;
    logic tx_active;
    logic rx_active;
    logic speed100;
  } status_t;

  typedef struct packed {
    logic mdc;
    logic mdio;
    logic tx_en;
    logic act100;
    logic act10;
  } async_in_t;

  typedef enum logic [1:0] {
    HB_IDLE  = 2'h0,
    HB_WAIT  = 2'h1,
    HB_PULSE = 2'h3
  } hb_state_t;

endpackage

`default_nettype wire

/* ccs_sync2.sv */
/*
  Two-flop level synchroniser for a bundle of unrelated levels.
  Assumes each bit is a slow level; no bit pairs with another.
*/
`default_nettype none

module ccs_sync2
  import phy_ccs_pkg::*;
(
  // Clock and reset
  input  wire logic      clk,
  input  wire logic      rst_n,
  // Levels
  input  wire async_in_t d,
  output var  async_in_t q
);

  async_in_t meta_ff;

  // First stage feeds the second stage only
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_ff <= '0;
      q       <= '0;
    end else begin
      meta_ff <= d;
      q       <= meta_ff;
    end
  end

endmodule

`default_nettype wire

/* ccs_rx_activity.sv */
/*
  Receive activity detection on the link clock.
  Assumes rx_bit is the recovered 100 Mb/s code bit stream and
  squelch_open / line_active come from the 10 Mb/s front end, all on clk_link.
*/
`default_nettype none
`include "phy_carrier_collision_status_regs.svh"

module ccs_rx_activity (
  // Link clock and reset
  input  wire logic clk_link,
  input  wire logic rst_n,
  // Front end
  input  wire logic rx_bit,
  input  wire logic squelch_open,
  input  wire logic line_active,
  // Activity levels
  output var  logic act100_ff,
  output var  logic act10_ff
);

  logic                   rst_meta_ff;
  logic                   rst_link_n_ff;
  logic [`SYM_BITS-1:0]   sym_ff;
  logic [`SYM_BITS-1:0]   nxt_sym;
  logic                   gapped;

  // Two zeros with at least one bit between them
  function automatic logic two_gapped_zeros(input logic [`SYM_BITS-1:0] s);
    logic hit;
    hit = 1'b0;
    for (int i = 0; i < `SYM_BITS; i++) begin
      for (int j = i + 2; j < `SYM_BITS; j++) begin
        if (!s[i] && !s[j]) begin
          hit = 1'b1;
        end
      end
    end
    return hit;
  endfunction

  // Release of reset is retimed to the link clock
  always_ff @(posedge clk_link or negedge rst_n) begin
    if (!rst_n) begin
      rst_meta_ff   <= 1'b0;
      rst_link_n_ff <= 1'b0;
    end else begin
      rst_meta_ff   <= 1'b1;
      rst_link_n_ff <= rst_meta_ff;
    end
  end

  assign nxt_sym = {sym_ff[`SYM_BITS-2:0], rx_bit};
  assign gapped  = two_gapped_zeros(nxt_sym);

  // Sliding window: every alignment is a candidate symbol
  always_ff @(posedge clk_link or negedge rst_link_n_ff) begin
    if (!rst_link_n_ff) begin
      sym_ff    <= `SYM_IDLE;
      act100_ff <= 1'b0;
      act10_ff  <= 1'b0;
    end else begin
      sym_ff    <= nxt_sym;
      act100_ff <= gapped;
      act10_ff  <= squelch_open && line_active;
    end
  end

endmodule

`default_nettype wire

/* ccs_checker.sv */
/*
  Assertions on carrier sense, collision and speed output.
  Assumes the block's ports only; CTRL is shadowed from bus writes.
*/
`default_nettype none

module ccs_checker (
  // Clock and reset
  input wire logic        CLK,
  input wire logic        RST_N,
  // Bus
  input wire logic        HSEL,
  input wire logic        HREADY,
  input wire logic [31:0] HADDR,
  input wire logic [1:0]  HTRANS,
  input wire logic        HWRITE,
  input wire logic [2:0]  HSIZE,
  input wire logic [31:0] HWDATA,
  // MAC side and front end
  input wire logic        TX_EN,
  input wire logic        CRS,
  input wire logic        COL,
  input wire logic        SPEED_OUT,
  input wire logic        SQUELCH_OPEN,
  input wire logic        LINE_ACTIVE
);
  logic       wr_ff;
  logic [3:0] ctrl_ff;
  wire        wr_ctrl = HSEL && HREADY && HTRANS[1] && HWRITE && (HSIZE == 3'h2)
                        && (HADDR == 32'h0);
  wire        rx10    = SQUELCH_OPEN && LINE_ACTIVE;
  wire        slow    = !ctrl_ff[0];
  wire        half    = !ctrl_ff[1] && !ctrl_ff[2];

  // Shadow lands on the same edge as the real register
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      wr_ff   <= 1'b0;
      ctrl_ff <= 4'h0;
    end else begin
      wr_ff   <= wr_ctrl;
      ctrl_ff <= wr_ff ? HWDATA[3:0] : ctrl_ff;
    end
  end

  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_N);

  sequence s_hb_arm;
    $fell(TX_EN) && slow && !ctrl_ff[1] && !ctrl_ff[3];
  endsequence
  sequence s_hb_pulse;
    ##[96:110] COL;
  endsequence

  property p_speed;
    SPEED_OUT == ctrl_ff[0];
  endproperty
  property p_fd_col;
    ctrl_ff[1] [*3] |-> !COL;
  endproperty
  property p_tx_crs;
    (TX_EN && half) [*5] |-> CRS;
  endproperty
  property p_tx_col;
    (TX_EN && half && slow && rx10) [*7] |-> COL;
  endproperty
  property p_rx_crs;
    (slow && rx10) [*7] |-> CRS;
  endproperty
  property p_own_tx;
    (TX_EN && !half && slow && !rx10) [*7] |-> !CRS;
  endproperty
  property p_hb;
    s_hb_arm |-> s_hb_pulse;
  endproperty
  property p_hb_quiet;
    (slow && half && ctrl_ff[3] && !TX_EN && !rx10) [*8] |-> !COL;
  endproperty

  a_speed: assert property (p_speed) else $error("speed output wrong");
  a_fd_col: assert property (p_fd_col) else $error("collision in full duplex");
  a_tx_crs: assert property (p_tx_crs) else $error("no carrier on transmit");
  a_tx_col: assert property (p_tx_col) else $error("collision missed");
  a_rx_crs: assert property (p_rx_crs) else $error("no carrier on receive");
  a_own_tx: assert property (p_own_tx) else $error("carrier on own transmit");
  a_hb: assert property (p_hb) else $error("heartbeat pulse missing");
  a_hb_quiet: assert property (p_hb_quiet) else $error("heartbeat not suppressed");
endmodule

bind phy_carrier_collision_status ccs_checker u_chk (
  .CLK, .RST_N, .HSEL, .HREADY, .HADDR, .HTRANS, .HWRITE, .HSIZE, .HWDATA,
  .TX_EN, .CRS, .COL, .SPEED_OUT, .SQUELCH_OPEN, .LINE_ACTIVE
);

`default_nettype wire

/* ccs_mac_model.sv */
/*
  MAC side of the MII status signals.
  Assumes tx_go from the bench marks a frame, on the system clock.
*/
`default_nettype none

module ccs_mac_model (
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst_n,
  // Bench control
  input  wire logic tx_go,
  // MII status
  input  wire logic crs,
  input  wire logic col,
  output var  logic tx_en_ff,
  // Synchronised view
  output var  logic crs_s,
  output var  logic col_s
);
  logic [1:0] crs_q_ff;
  logic [1:0] col_q_ff;

  assign crs_s = crs_q_ff[1];
  assign col_s = col_q_ff[1];

  // Status arrives with no clock relation, so two flops first
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      crs_q_ff <= 2'h0;
      col_q_ff <= 2'h0;
      tx_en_ff <= 1'b0;
    end else begin
      crs_q_ff <= {crs_q_ff[0], crs};
      col_q_ff <= {col_q_ff[0], col};
      tx_en_ff <= tx_go;
    end
  end
endmodule

`default_nettype wire

/* phy_carrier_collision_status_tb.sv */
/*
  Self-checking bench of the carrier and collision status block.
  Assumes the MAC model on the MII side; the bench is bus master,
  link front end and station manager.
*/
`default_nettype none
`include "phy_carrier_collision_status_regs.svh"

module phy_carrier_collision_status_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        CLK = 1'b0, LINK_CLK = 1'b0, RST_N = 1'b0, RX_BIT = 1'b1;
  logic        HSEL = 1'b0, HWRITE = 1'b0, tx_go = 1'b0, MDC = 1'b0, MDIO_I = 1'b0;
  logic        SQUELCH_OPEN = 1'b0, LINE_ACTIVE = 1'b0;
  logic        HREADYOUT, HRESP, TX_EN, CRS, COL, SPEED_OUT, crs_s, col_s;
  logic [1:0]  HTRANS = 2'h0;
  logic [2:0]  HSIZE = 3'h2;
  logic [4:0]  idx = 5'h00;
  logic [19:0] pat = {2{`SYM_IDLE}};
  logic [31:0] HADDR = 32'h0, HWDATA = 32'h0, HRDATA;
  int          error_cnt = 0, n_checks = 0;

  phy_carrier_collision_status uut (
    .CLK, .RST_N, .HSEL, .HADDR, .HTRANS, .HWRITE, .HSIZE, .HWDATA,
    .HREADY(HREADYOUT), .HRDATA, .HREADYOUT, .HRESP, .TX_EN, .CRS, .COL,
    .SPEED_OUT, .LINK_CLK, .RX_BIT, .SQUELCH_OPEN, .LINE_ACTIVE, .MDC, .MDIO_I
  );
  ccs_mac_model mac (
    .clk(CLK), .rst_n(RST_N), .tx_go, .crs(CRS), .col(COL),
    .tx_en_ff(TX_EN), .crs_s, .col_s
  );

  // No reference input here; the board's 25 MHz source stays outside
  initial forever #4 CLK = ~CLK;
  // Recovered clock keeps running between frames
  initial begin
    #1.3;
    forever #3 LINK_CLK = ~LINK_CLK;
  end
  // Two symbol periods, so a lone zero pair is never split by a wrap
  always @(posedge LINK_CLK) begin
    RX_BIT <= pat[idx];
    idx    <= (idx == 5'h13) ? 5'h00 : idx + 5'h01;
  end

  task automatic complete_run();
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge CLK);
  endtask

  task automatic bus(input logic wr, input logic [31:0] a, d, output logic [31:0] r);
    int k = 0;
    HSEL   <= 1'b1;
    HTRANS <= 2'h2;
    HADDR  <= a;
    HWRITE <= wr;
    do begin
      @(posedge CLK);
      k++;
    end while (HREADYOUT !== 1'b1 && k < 50);
    HSEL   <= 1'b0;
    HTRANS <= 2'h0;
    HWDATA <= d;
    do begin
      @(posedge CLK);
      k++;
    end while (HREADYOUT !== 1'b1 && k < 50);
    r = HRDATA;
    chk("HRESP", `HRESP_OKAY, HRESP);
    if (k >= 50) begin
      error_cnt++;
      complete_run();
    end
  endtask

  task automatic wr(input logic [31:0] a, d);
    logic [31:0] r;
    bus(1'b1, a, d, r);
  endtask

  task automatic rd_chk(input string what, input logic [31:0] a, exp);
    logic [31:0] r;
    bus(1'b0, a, 32'h0, r);
    chk(what, exp, r);
  endtask

  task automatic tx(input logic v);
    tx_go <= v;
    cyc(10);
  endtask

  task automatic rx(input logic v);
    SQUELCH_OPEN <= v;
    LINE_ACTIVE  <= v;
    cyc(10);
  endtask

  // Absence shows as a delay at the bound
  task automatic hb(output int dly, len);
    dly = 0;
    len = 0;
    while (COL !== 1'b1 && dly < 200) begin
      @(posedge CLK);
      dly++;
    end
    while (COL === 1'b1 && len < 200) begin
      @(posedge CLK);
      len++;
    end
  endtask

  task automatic t_mgmt();
    logic [3:0] bits = 4'hb;
    for (int i = 3; i >= 0; i--) begin
      MDIO_I <= bits[i];
      cyc(4);
      MDC <= 1'b1;
      cyc(4);
      MDC <= 1'b0;
    end
    cyc(4);
    rd_chk("MGMT", `MGMT_OFS, 32'h0000_000b);
  endtask

  task automatic t_speed();
    wr(`CTRL_OFS, 32'h0000_0001);
    cyc(1);
    chk("SPEED_OUT", 1, SPEED_OUT);
    rd_chk("CTRL", `CTRL_OFS, 32'h0000_0001);
    rd_chk("STATUS speed", `STATUS_OFS, 32'h0000_0001);
    rd_chk("unmapped", 32'h0000_0010, 32'h0);
    wr(`CTRL_OFS, 32'h0);
    cyc(1);
    chk("SPEED_OUT", 0, SPEED_OUT);
  endtask

  task automatic t_half();
    int dly, len;
    rx(1'b1);
    chk("CRS rx", 1, crs_s);
    chk("COL rx", 0, col_s);
    tx(1'b1);
    chk("COL both", 1, col_s);
    rx(1'b0);
    chk("CRS tx", 1, crs_s);
    tx_go <= 1'b0;
    hb(dly, len);
    chk("hb delay", 1, dly inside {[100:110]});
    chk("hb length", 125, len);
  endtask

  task automatic t_supp();
    int dly, len;
    wr(`CTRL_OFS, 32'h0000_0008);
    tx(1'b1);
    tx_go <= 1'b0;
    hb(dly, len);
    chk("hb suppressed", 200, dly);
  endtask

  task automatic t_fd_rep();
    wr(`CTRL_OFS, 32'h0000_0002);
    tx(1'b1);
    chk("CRS fd own tx", 0, crs_s);
    rx(1'b1);
    chk("COL fd", 0, col_s);
    chk("CRS fd rx", 1, crs_s);
    rx(1'b0);
    tx(1'b0);
    wr(`CTRL_OFS, 32'h0000_000c);
    tx(1'b1);
    chk("CRS repeater tx", 0, crs_s);
    tx(1'b0);
  endtask

  task automatic t_100();
    wr(`CTRL_OFS, 32'h0000_0001);
    tx(1'b1);
    pat <= {`SYM_IDLE, 10'h39f};
    cyc(24);
    chk("COL adjacent zeros", 0, col_s);
    pat <= {2{10'h35f}};
    cyc(24);
    chk("COL split zeros", 1, col_s);
    pat <= {2{`SYM_IDLE}};
    tx(1'b0);
  endtask

  task automatic t_rst();
    wr(`CTRL_OFS, 32'h0000_0008);
    rx(1'b1);
    chk("CRS before reset", 1, CRS);
    RST_N <= 1'b0;
    cyc(1);
    chk("CRS in reset", 0, CRS);
    rx(1'b0);
    RST_N <= 1'b1;
    cyc(2);
    rd_chk("CTRL after reset", `CTRL_OFS, 32'h0);
    rx(1'b1);
    rd_chk("STATUS rx", `STATUS_OFS, 32'h0000_000a);
    rd_chk("COUNT one rise", `COUNT_OFS, 32'h0000_0001);
    wr(`COUNT_OFS, 32'h0);
    rd_chk("COUNT cleared", `COUNT_OFS, 32'h0);
    rx(1'b0);
  endtask

  initial begin
    cyc(12);
    RST_N <= 1'b1;
    cyc(1);
    chk("COL after reset", 0, COL);
    chk("SPEED after reset", 0, SPEED_OUT);
    t_mgmt();
    t_speed();
    t_half();
    t_supp();
    t_fd_rep();
    t_100();
    t_rst();
    complete_run();
  end
endmodule

`default_nettype wire
